/* hw/efs_supervisor.sv */
`timescale 1ns/1ps
`include "efs_params.svh"
// Function
// [RULE_01] flag overcurrent when control signal below threshold
// [RULE_02] overcurrent detection qualified by active current limiter
// [RULE_03] overcurrent threshold in 0.01 steps, default 1.00
// [RULE_04] overcurrent trip after delay, 5 ms steps
// [RULE_05] open field: signal high and current low
// [RULE_06] open field persisting: trip rectifier, stop excitation
// [RULE_07] open field delay 5 ms steps, default 3 s
// [RULE_08] open field signal threshold, default 1.00
// [RULE_09] open field current threshold, default 0.10
// [RULE_10] temperature alarm at level, always active
// [RULE_11] breaker off: run down, then open breaker
// [RULE_12] event if breaker not open in time
// [RULE_13] inverter stopping time 0.1 s steps, default 1 s
// [RULE_14] forced source ramps control signal at rate
// [RULE_15] delay timers restart when condition drops
module efs_supervisor #(
  parameter int unsigned TICK_CYCLES = `EFS_TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // measurements and plant status
  input  wire logic [15:0] ctrlSigIn,
  input  wire logic [15:0] fieldCurrent,
  input  wire logic [7:0]  switchTemp,
  input  wire logic        limiterActive,
  input  wire logic        machCircuitOpen,
  input  wire logic        breakerOffCmd,
  input  wire logic        breakerIsOpen,
  // commands
  output logic [15:0]      ctrlSigOut,
  output logic             fieldOcTrip,
  output logic             rectifierTrip,
  output logic             excitationStop,
  output logic             inverterRunDown,
  output logic             breakerOpenCmd,
  output logic             tempAlarm,
  output logic             breakerTimeoutEvt
);
  logic [`EFS_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [15:0]            ocThr_ff, nxt_ocThr;
  logic [15:0]            ocDly_ff, nxt_ocDly;
  logic [15:0]            ofDly_ff, nxt_ofDly;
  logic [15:0]            ofCsHi_ff, nxt_ofCsHi;
  logic [15:0]            ofIfLo_ff, nxt_ofIfLo;
  logic [7:0]             tempLvl_ff, nxt_tempLvl;
  logic [15:0]            brkTrip_ff, nxt_brkTrip;
  logic [15:0]            invStop_ff, nxt_invStop;
  logic [7:0]             rampRate_ff, nxt_rampRate;
  logic                   ack_ff, nxt_ack;
  logic [31:0]            datO_ff, nxt_datO;
  logic [31:0]            wmask;
  logic [31:0]            wdat;
  logic                   busHit;
  logic                   wrEn;

  logic [31:0]            divCnt_ff, nxt_divCnt;
  logic [7:0]             slowCnt_ff, nxt_slowCnt;
  logic                   tick_ff, nxt_tick;
  logic                   slowTick_ff, nxt_slowTick;

  logic [15:0]            ctrlSigOut_ff, nxt_ctrlSigOut;
  logic [15:0]            ctrlEff;
  logic [15:0]            rampLevel;
  logic                   ocDetect, ofDetect;
  logic                   ocExpired, ofExpired, invExpired, brkExpired;
  logic                   ocDet_ff, ofDet_ff;
  logic                   ocTrip_ff, nxt_ocTrip;
  logic                   ofTrip_ff, nxt_ofTrip;
  logic                   temp_ff, nxt_temp;
  logic                   tmo_ff, nxt_tmo;
  logic                   tmoPulse;
  efs_pkg::efs_brk_state_t brk_ff, nxt_brk;
  logic                   runDown_ff, nxt_runDown;
  logic                   brkCmd_ff, nxt_brkCmd;
  logic [`EFS_ST_W-1:0]   status;

  // ---------------- wishbone slave ----------------
  assign busHit = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wrEn   = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  assign status = {brkCmd_ff, runDown_ff, tmo_ff, temp_ff, ofTrip_ff, ofDet_ff, ocTrip_ff,
                   ocDet_ff};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_ocThr    = ocThr_ff;
    nxt_ocDly    = ocDly_ff;
    nxt_ofDly    = ofDly_ff;
    nxt_ofCsHi   = ofCsHi_ff;
    nxt_ofIfLo   = ofIfLo_ff;
    nxt_tempLvl  = tempLvl_ff;
    nxt_brkTrip  = brkTrip_ff;
    nxt_invStop  = invStop_ff;
    nxt_rampRate = rampRate_ff;
    nxt_ack      = busHit;
    nxt_datO     = 32'h0000_0000;
    wdat         = 32'h0000_0000;
    case (wb_adr_i)
      `EFS_OFS_CTRL: begin
        wdat = merge({26'h0, ctrl_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_ctrl = wdat[`EFS_CTRL_W-1:0];
        nxt_datO = {26'h0, ctrl_ff};
      end
      `EFS_OFS_OC_THR: begin
        wdat = merge({16'h0, ocThr_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_ocThr = wdat[15:0]; // RULE_03
        nxt_datO = {16'h0, ocThr_ff};
      end
      `EFS_OFS_OC_DLY: begin
        wdat = merge({16'h0, ocDly_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_ocDly = wdat[15:0];
        nxt_datO = {16'h0, ocDly_ff};
      end
      `EFS_OFS_OF_DLY: begin
        wdat = merge({16'h0, ofDly_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_ofDly = wdat[15:0]; // RULE_07
        nxt_datO = {16'h0, ofDly_ff};
      end
      `EFS_OFS_OF_CS_HI: begin
        wdat = merge({16'h0, ofCsHi_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_ofCsHi = wdat[15:0]; // RULE_08
        nxt_datO = {16'h0, ofCsHi_ff};
      end
      `EFS_OFS_OF_IF_LO: begin
        wdat = merge({16'h0, ofIfLo_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_ofIfLo = wdat[15:0]; // RULE_09
        nxt_datO = {16'h0, ofIfLo_ff};
      end
      `EFS_OFS_TEMP_LVL: begin
        wdat = merge({24'h0, tempLvl_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_tempLvl = wdat[7:0];
        nxt_datO = {24'h0, tempLvl_ff};
      end
      `EFS_OFS_BRK_TRIP: begin
        wdat = merge({16'h0, brkTrip_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_brkTrip = wdat[15:0];
        nxt_datO = {16'h0, brkTrip_ff};
      end
      `EFS_OFS_INV_STOP: begin
        wdat = merge({16'h0, invStop_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_invStop = wdat[15:0]; // RULE_13
        nxt_datO = {16'h0, invStop_ff};
      end
      `EFS_OFS_RAMP_RATE: begin
        wdat = merge({24'h0, rampRate_ff}, wb_dat_i, wmask);
        if (wrEn) nxt_rampRate = wdat[7:0];
        nxt_datO = {24'h0, rampRate_ff};
      end
      `EFS_OFS_STATUS: begin
        wdat = wb_dat_i & wmask;
        nxt_datO = {24'h0, status};
      end
      default: begin
        // unmapped words acknowledge and read as zero
        wdat = 32'h0000_0000;
      end
    endcase
    if (!busHit) begin
      nxt_datO = datO_ff;
    end
  end

  // ---------------- time base ----------------
  // one divider makes the 5 ms tick; the 0.1 s breaker tick is 20 of those
  always_comb begin
    nxt_divCnt   = divCnt_ff + 32'h0000_0001;
    nxt_tick     = 1'b0;
    nxt_slowCnt  = slowCnt_ff;
    nxt_slowTick = 1'b0;
    if (divCnt_ff >= TICK_CYCLES - 1) begin
      nxt_divCnt = 32'h0000_0000;
      nxt_tick   = 1'b1;
      if (slowCnt_ff >= `EFS_TICKS_PER_SLOW - 8'h01) begin
        nxt_slowCnt  = 8'h00;
        nxt_slowTick = 1'b1;
      end else begin
        nxt_slowCnt = slowCnt_ff + 8'h01;
      end
    end
  end

  // ---------------- detection ----------------
  efs_ramp_gen u_ramp (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tickEn   (tick_ff),
    .active   (ctrl_ff[`EFS_CTRL_FORCE]),
    .rampUp   (ctrl_ff[`EFS_CTRL_UP]),
    .rampDown (ctrl_ff[`EFS_CTRL_DOWN]),
    .rate     (rampRate_ff),
    .seed     (ctrlSigIn),
    .level    (rampLevel)
  );

  // forced source is meant for bench testing of the power stage only
  assign ctrlEff = ctrl_ff[`EFS_CTRL_FORCE] ? rampLevel : ctrlSigIn; // RULE_14

  assign ocDetect = ctrl_ff[`EFS_CTRL_OC_EN] && limiterActive // RULE_02
                    && (ctrlEff < ocThr_ff); // RULE_01
  assign ofDetect = ctrl_ff[`EFS_CTRL_OF_EN] && (ctrlEff > ofCsHi_ff)
                    && (fieldCurrent <= ofIfLo_ff); // RULE_05

  efs_delay_timer u_ocTimer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tickEn   (tick_ff),
    .cond     (ocDetect),
    .limit    (ocDly_ff),
    .expired  (ocExpired)
  );

  efs_delay_timer u_ofTimer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tickEn   (tick_ff),
    .cond     (ofDetect),
    .limit    (ofDly_ff),
    .expired  (ofExpired)
  );

  efs_delay_timer u_invTimer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tickEn   (slowTick_ff),
    .cond     (brk_ff == efs_pkg::BRK_RUNDOWN),
    .limit    (invStop_ff),
    .expired  (invExpired)
  );

  efs_delay_timer u_brkTimer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tickEn   (slowTick_ff),
    .cond     (brk_ff == efs_pkg::BRK_WAIT && !breakerIsOpen),
    .limit    (brkTrip_ff),
    .expired  (brkExpired)
  );

  // ---------------- breaker sequence ----------------
  always_comb begin
    nxt_brk     = brk_ff;
    tmoPulse    = 1'b0;
    case (brk_ff)
      efs_pkg::BRK_IDLE: begin
        if (ctrl_ff[`EFS_CTRL_BRK_EN] && machCircuitOpen && breakerOffCmd) begin
          nxt_brk = efs_pkg::BRK_RUNDOWN; // RULE_11
        end
      end
      efs_pkg::BRK_RUNDOWN: begin
        if (invExpired) nxt_brk = efs_pkg::BRK_WAIT; // RULE_11
      end
      efs_pkg::BRK_WAIT: begin
        if (breakerIsOpen) begin
          nxt_brk = efs_pkg::BRK_DONE;
        end else if (brkExpired) begin
          tmoPulse = 1'b1; // RULE_12
          nxt_brk  = efs_pkg::BRK_DONE;
        end
      end
      efs_pkg::BRK_DONE: begin
        if (!breakerOffCmd) nxt_brk = efs_pkg::BRK_IDLE;
      end
      default: nxt_brk = efs_pkg::BRK_IDLE;
    endcase
    nxt_runDown = (nxt_brk == efs_pkg::BRK_RUNDOWN);
    nxt_brkCmd  = (nxt_brk == efs_pkg::BRK_WAIT) || (nxt_brk == efs_pkg::BRK_DONE);
  end

  // ---------------- sticky trip and timeout flags, set beats clear; temperature flag is live ----------------
  always_comb begin
    nxt_ocTrip = ocTrip_ff;
    nxt_ofTrip = ofTrip_ff;
    nxt_tmo    = tmo_ff;
    if (wrEn && wb_adr_i == `EFS_OFS_STATUS) begin
      if (wdat[`EFS_ST_OC_TRIP]) nxt_ocTrip = 1'b0;
      if (wdat[`EFS_ST_OF_TRIP]) nxt_ofTrip = 1'b0;
      if (wdat[`EFS_ST_BRK_TMO]) nxt_tmo = 1'b0;
    end
    if (ocExpired) nxt_ocTrip = 1'b1; // RULE_04
    if (ofExpired) nxt_ofTrip = 1'b1; // RULE_06
    if (tmoPulse) nxt_tmo = 1'b1; // RULE_12
    nxt_temp       = (switchTemp >= tempLvl_ff); // RULE_10
    nxt_ctrlSigOut = ctrlEff;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff       <= `EFS_RST_CTRL;
      ocThr_ff      <= `EFS_RST_OC_THR;
      ocDly_ff      <= `EFS_RST_OC_DLY;
      ofDly_ff      <= `EFS_RST_OF_DLY;
      ofCsHi_ff     <= `EFS_RST_OF_CS_HI;
      ofIfLo_ff     <= `EFS_RST_OF_IF_LO;
      tempLvl_ff    <= `EFS_RST_TEMP_LVL;
      brkTrip_ff    <= `EFS_RST_BRK_TRIP;
      invStop_ff    <= `EFS_RST_INV_STOP;
      rampRate_ff   <= `EFS_RST_RAMP_RATE;
      ack_ff        <= 1'b0;
      datO_ff       <= 32'h0000_0000;
      divCnt_ff     <= 32'h0000_0000;
      slowCnt_ff    <= 8'h00;
      tick_ff       <= 1'b0;
      slowTick_ff   <= 1'b0;
      ctrlSigOut_ff <= 16'h0000;
      ocDet_ff      <= 1'b0;
      ofDet_ff      <= 1'b0;
      ocTrip_ff     <= 1'b0;
      ofTrip_ff     <= 1'b0;
      temp_ff       <= 1'b0;
      tmo_ff        <= 1'b0;
      brk_ff        <= efs_pkg::BRK_IDLE;
      runDown_ff    <= 1'b0;
      brkCmd_ff     <= 1'b0;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      ocThr_ff      <= nxt_ocThr;
      ocDly_ff      <= nxt_ocDly;
      ofDly_ff      <= nxt_ofDly;
      ofCsHi_ff     <= nxt_ofCsHi;
      ofIfLo_ff     <= nxt_ofIfLo;
      tempLvl_ff    <= nxt_tempLvl;
      brkTrip_ff    <= nxt_brkTrip;
      invStop_ff    <= nxt_invStop;
      rampRate_ff   <= nxt_rampRate;
      ack_ff        <= nxt_ack;
      datO_ff       <= nxt_datO;
      divCnt_ff     <= nxt_divCnt;
      slowCnt_ff    <= nxt_slowCnt;
      tick_ff       <= nxt_tick;
      slowTick_ff   <= nxt_slowTick;
      ctrlSigOut_ff <= nxt_ctrlSigOut;
      ocDet_ff      <= ocDetect;
      ofDet_ff      <= ofDetect;
      ocTrip_ff     <= nxt_ocTrip;
      ofTrip_ff     <= nxt_ofTrip;
      temp_ff       <= nxt_temp;
      tmo_ff        <= nxt_tmo;
      brk_ff        <= nxt_brk;
      runDown_ff    <= nxt_runDown;
      brkCmd_ff     <= nxt_brkCmd;
    end
  end

  assign wb_ack_o          = ack_ff;
  assign wb_dat_o          = datO_ff;
  assign ctrlSigOut        = ctrlSigOut_ff;
  assign fieldOcTrip       = ocTrip_ff;
  assign rectifierTrip     = ofTrip_ff;
  assign excitationStop    = ofTrip_ff; // RULE_06
  assign inverterRunDown   = runDown_ff;
  assign breakerOpenCmd    = brkCmd_ff;
  assign tempAlarm         = temp_ff;
  assign breakerTimeoutEvt = tmo_ff;
endmodule : efs_supervisor

/* hw/efs_params.svh */
`ifndef EFS_PARAMS_SVH
`define EFS_PARAMS_SVH

// clock and time base
`define EFS_CLK_PS         5000
`define EFS_TICK_MS        5
`define EFS_TICK_CYCLES    ((`EFS_TICK_MS * 1000 * 1000) / `EFS_CLK_PS * 1000)
`define EFS_TICKS_PER_SLOW 8'h14
`define EFS_TICKS_PER_SEC  16'h00C8

// register byte offsets
`define EFS_OFS_CTRL       6'h00
`define EFS_OFS_OC_THR     6'h04
`define EFS_OFS_OC_DLY     6'h08
`define EFS_OFS_OF_DLY     6'h0C
`define EFS_OFS_OF_CS_HI   6'h10
`define EFS_OFS_OF_IF_LO   6'h14
`define EFS_OFS_TEMP_LVL   6'h18
`define EFS_OFS_BRK_TRIP   6'h1C
`define EFS_OFS_INV_STOP   6'h20
`define EFS_OFS_RAMP_RATE  6'h24
`define EFS_OFS_STATUS     6'h28

// control register fields
`define EFS_CTRL_OC_EN     0
`define EFS_CTRL_OF_EN     1
`define EFS_CTRL_BRK_EN    2
`define EFS_CTRL_FORCE     3
`define EFS_CTRL_UP        4
`define EFS_CTRL_DOWN      5
`define EFS_CTRL_W         6

// status register fields
`define EFS_ST_OC_DET      0
`define EFS_ST_OC_TRIP     1
`define EFS_ST_OF_DET      2
`define EFS_ST_OF_TRIP     3
`define EFS_ST_TEMP        4
`define EFS_ST_BRK_TMO     5
`define EFS_ST_RUNDOWN     6
`define EFS_ST_BRK_CMD     7
`define EFS_ST_W           8

// reset values: signals in 0.01 units, delays in 5 ms, breaker times in 0.1 s
`define EFS_RST_CTRL       6'h00
`define EFS_RST_OC_THR     16'h0064
`define EFS_RST_OC_DLY     16'h0258
`define EFS_RST_OF_DLY     16'h0258
`define EFS_RST_OF_CS_HI   16'h0064
`define EFS_RST_OF_IF_LO   16'h000A
`define EFS_RST_TEMP_LVL   8'h64
`define EFS_RST_BRK_TRIP   16'h0005
`define EFS_RST_INV_STOP   16'h000A
`define EFS_RST_RAMP_RATE  8'h02
`define EFS_SIG_MAX        16'h09C4

`endif

/* hw/efs_pkg.sv */
package efs_pkg;
  typedef enum logic [1:0] {
    BRK_IDLE    = 2'b00,
    BRK_RUNDOWN = 2'b01,
    BRK_WAIT    = 2'b10,
    BRK_DONE    = 2'b11
  } efs_brk_state_t;
endpackage : efs_pkg

/* hw/efs_delay_timer.sv */
`timescale 1ns/1ps
`include "efs_params.svh"
module efs_delay_timer (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        tickEn,
  input  wire logic        cond,
  input  wire logic [15:0] limit,
  output logic             expired
);
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic        expired_ff;
  logic        nxt_expired;

  // the count restarts the moment the condition drops, so only a continuous
  // condition can reach the limit
  always_comb begin
    nxt_count = count_ff;
    if (!cond) begin
      nxt_count = 16'h0000; // RULE_15
    end else if (tickEn && count_ff != 16'hFFFF) begin
      nxt_count = count_ff + 16'h0001;
    end
    nxt_expired = cond && (count_ff >= limit);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff   <= 16'h0000;
      expired_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign expired = expired_ff;
endmodule : efs_delay_timer

/* hw/efs_ramp_gen.sv */
`timescale 1ns/1ps
`include "efs_params.svh"
module efs_ramp_gen (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        tickEn,
  input  wire logic        active,
  input  wire logic        rampUp,
  input  wire logic        rampDown,
  input  wire logic [7:0]  rate,
  input  wire logic [15:0] seed,
  output logic [15:0]      level
);
  logic [15:0] level_ff;
  logic [15:0] nxt_level;
  logic [15:0] acc_ff;
  logic [15:0] nxt_acc;
  logic [15:0] sum;

  // rate is in 0.01 per second; 200 ticks make a second, so a step of 0.01
  // is taken each time the accumulator passes 200
  always_comb begin
    sum       = acc_ff + {8'h00, rate};
    nxt_level = level_ff;
    nxt_acc   = acc_ff;
    if (!active) begin
      // track the live signal so that selecting the forced source is bumpless
      nxt_level = seed;
      nxt_acc   = 16'h0000;
    end else if (tickEn && (rampUp ^ rampDown)) begin
      if (sum >= `EFS_TICKS_PER_SEC) begin
        nxt_acc = sum - `EFS_TICKS_PER_SEC;
        if (rampUp && level_ff < `EFS_SIG_MAX) begin
          nxt_level = level_ff + 16'h0001;
        end else if (rampDown && level_ff != 16'h0000) begin
          nxt_level = level_ff - 16'h0001;
        end
      end else begin
        nxt_acc = sum;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_ff <= 16'h0000;
      acc_ff   <= 16'h0000;
    end else begin
      level_ff <= nxt_level;
      acc_ff   <= nxt_acc;
    end
  end

  assign level = level_ff;
endmodule : efs_ramp_gen

/* bench/efs_supervisor_monitor.sv */
`timescale 1ns/1ps
`include "efs_params.svh"
module efs_supervisor_monitor (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  switchTemp,
  input wire logic        limiterActive,
  input wire logic        breakerIsOpen,
  input wire logic        breakerOffCmd,
  input wire logic        machCircuitOpen,
  input wire logic        fieldOcTrip,
  input wire logic        rectifierTrip,
  input wire logic        excitationStop,
  input wire logic        inverterRunDown,
  input wire logic        breakerOpenCmd,
  input wire logic        tempAlarm,
  input wire logic        breakerTimeoutEvt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic       take;
  logic [7:0] tempLvl_ff;
  logic [7:0] nxt_tempLvl;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // level shadow; writes land at the acknowledged edge
  always_comb begin
    nxt_tempLvl = tempLvl_ff;
    if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == `EFS_OFS_TEMP_LVL) begin
      nxt_tempLvl = wb_dat_i[7:0];
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tempLvl_ff <= 8'h64;
    end else begin
      tempLvl_ff <= nxt_tempLvl;
    end
  end
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_follows:
    assert property (take |=> wb_ack_o) else $error("request not answered");
  a_ack_cause:
    assert property ($rose(wb_ack_o) |-> $past(take)) else $error("ack without request");
  a_temp_level:
    assert property ($past(rst_b) |-> tempAlarm == ($past(switchTemp) >= $past(tempLvl_ff)))
      else $error("temperature alarm wrong");
  a_oc_limiter:
    assert property ((!limiterActive)[*6] |=> !$rose(fieldOcTrip))
      else $error("trip without limiter");
  a_of_sticky:
    assert property (rectifierTrip && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> rectifierTrip)
      else $error("rectifier trip lost");
  a_stop_trip:
    assert property (excitationStop == rectifierTrip) else $error("stop differs from trip");
  a_rundown_cause:
    assert property ($rose(inverterRunDown) |-> $past(breakerOffCmd) && $past(machCircuitOpen))
      else $error("run-down uncommanded");
  a_open_order:
    assert property ($rose(breakerOpenCmd) |-> $past(inverterRunDown))
      else $error("open without run-down");
  a_tmo_cause:
    assert property ($rose(breakerTimeoutEvt) |-> $past(breakerOpenCmd && !breakerIsOpen))
      else $error("timeout without pending trip");
endmodule : efs_supervisor_monitor

bind efs_supervisor efs_supervisor_monitor u_mon (
  .core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .switchTemp, .limiterActive, .breakerIsOpen, .breakerOffCmd, .machCircuitOpen,
  .fieldOcTrip, .rectifierTrip, .excitationStop, .inverterRunDown, .breakerOpenCmd,
  .tempAlarm, .breakerTimeoutEvt
);

/* bench/efs_breaker_model.sv */
`timescale 1ns/1ps
module efs_breaker_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        openCmd,
  input  wire logic        stuck,
  input  wire logic [15:0] openDelay,
  output logic             isOpen
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        nxt_open;
  // a stuck breaker never opens
  always_comb begin
    nxt_cnt  = 16'h0000;
    nxt_open = 1'b0;
    if (openCmd && !stuck) begin
      nxt_open = (cnt_ff == openDelay);
      nxt_cnt  = nxt_open ? cnt_ff : cnt_ff + 16'h0001;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 16'h0000;
      isOpen <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      isOpen <= nxt_open;
    end
  end
endmodule : efs_breaker_model

/* bench/efs_supervisor_tb_top.sv */
`timescale 1ns/1ps
`include "efs_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module efs_supervisor_tb_top;
  localparam logic [15:0] RST [11] = '{16'h0000, 16'h0064, 16'h0258, 16'h0258, 16'h0064,
    16'h000A, 16'h0064, 16'h0005, 16'h000A, 16'h0002, 16'h0000};
  logic        core_clk = 1'b0, rst_b = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic        wb_ack_o;
  logic [15:0] ctrlSigIn = 16'h0064, fieldCurrent = 16'h0032, ctrlSigOut, held;
  logic [7:0]  switchTemp = 8'h14;
  logic        limiterActive = 1'b0, machCircuitOpen = 1'b0, breakerOffCmd = 1'b0;
  logic        brkStuck = 1'b0, breakerIsOpen;
  logic        fieldOcTrip, rectifierTrip, excitationStop, inverterRunDown;
  logic        breakerOpenCmd, tempAlarm, breakerTimeoutEvt;
  int          n_fail = 0, cmp_count = 0, ticks = 0;

  efs_supervisor #(.TICK_CYCLES(10)) dut (
    .core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .ctrlSigIn, .fieldCurrent, .switchTemp, .limiterActive,
    .machCircuitOpen, .breakerOffCmd, .breakerIsOpen, .ctrlSigOut, .fieldOcTrip,
    .rectifierTrip, .excitationStop, .inverterRunDown, .breakerOpenCmd, .tempAlarm,
    .breakerTimeoutEvt);
  efs_breaker_model brk (.core_clk, .rst_b, .openCmd(breakerOpenCmd), .stuck(brkStuck),
    .openDelay(16'h0032), .isOpen(breakerIsOpen));

  always #2.5 core_clk = ~core_clk;

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    `CHK(wb_ack_o, 1'b1)
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic t_regs;
    for (int i = 0; i < 11; i++) begin
      wb(1'b0, 6'(4 * i), 32'h0);
      `CHK(q, RST[i])
    end
    wb(1'b1, 6'h3C, 32'hFFFF_FFFF);
    wb(1'b0, 6'h3C, 32'h0);
    `CHK(q, 32'h0000_0000)
    wb(1'b1, `EFS_OFS_STATUS, 32'h0000_00FF);
    wb(1'b0, `EFS_OFS_STATUS, 32'h0);
    `CHK(q, 32'h0000_0000)
    $display("regs done");
  endtask : t_regs

  task automatic t_ovc;
    wb(1'b1, `EFS_OFS_OC_THR, 32'h0000_0032);
    wb(1'b1, `EFS_OFS_OC_DLY, 32'h0000_0004);
    @(posedge core_clk) ctrlSigIn <= 16'h0028;
    limiterActive <= 1'b1;
    cyc(80);
    `CHK(fieldOcTrip, 1'b0)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0001);
    @(posedge core_clk) limiterActive <= 1'b0;
    cyc(80);
    `CHK(fieldOcTrip, 1'b0)
    @(posedge core_clk) limiterActive <= 1'b1;
    ctrlSigIn <= 16'h0032;
    cyc(80);
    `CHK(fieldOcTrip, 1'b0)
    @(posedge core_clk) ctrlSigIn <= 16'h0028;
    cyc(25);
    @(posedge core_clk) ctrlSigIn <= 16'h0064;
    cyc(5);
    @(posedge core_clk) ctrlSigIn <= 16'h0028;
    cyc(25);
    `CHK(fieldOcTrip, 1'b0)
    cyc(35);
    `CHK(fieldOcTrip, 1'b1)
    @(posedge core_clk) ctrlSigIn <= 16'h0064;
    wb(1'b1, `EFS_OFS_STATUS, 32'h0000_0002);
    cyc(3);
    `CHK(fieldOcTrip, 1'b0)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0000);
    $display("overcurrent done");
  endtask : t_ovc

  task automatic t_of;
    wb(1'b1, `EFS_OFS_OF_DLY, 32'h0000_0002);
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0002);
    @(posedge core_clk) fieldCurrent <= 16'h0005;
    cyc(60);
    `CHK(rectifierTrip, 1'b0)
    @(posedge core_clk) ctrlSigIn <= 16'h0096;
    fieldCurrent <= 16'h000B;
    cyc(60);
    `CHK(rectifierTrip, 1'b0)
    @(posedge core_clk) fieldCurrent <= 16'h000A;
    cyc(40);
    `CHK(rectifierTrip, 1'b1)
    `CHK(excitationStop, 1'b1)
    wb(1'b0, `EFS_OFS_STATUS, 32'h0);
    `CHK(q[3], 1'b1)
    @(posedge core_clk) fieldCurrent <= 16'h0032;
    wb(1'b1, `EFS_OFS_STATUS, 32'h0000_0008);
    cyc(3);
    `CHK(rectifierTrip, 1'b0)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0000);
    $display("open field done");
  endtask : t_of

  task automatic t_temp;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wb(1'b1, `EFS_OFS_TEMP_LVL, 32'h0000_0096);
      @(posedge core_clk) switchTemp <= (i < 2 ? 8'h63 : 8'h95) + 8'(i % 2);
      cyc(3);
      `CHK(tempAlarm, i[0])
    end
    @(posedge core_clk) switchTemp <= 8'h14;
    $display("temperature done");
  endtask : t_temp

  task automatic t_brk;
    wb(1'b1, `EFS_OFS_INV_STOP, 32'h0000_0002);
    wb(1'b1, `EFS_OFS_BRK_TRIP, 32'h0000_0003);
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0004);
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk) brkStuck <= r[0];
      breakerOffCmd <= 1'b1;
      cyc(20);
      `CHK(inverterRunDown, 1'b0)
      @(posedge core_clk) machCircuitOpen <= 1'b1;
      cyc(5);
      `CHK(inverterRunDown, 1'b1)
      cyc(185);
      `CHK(breakerOpenCmd, 1'b0)
      cyc(230);
      `CHK(breakerOpenCmd, 1'b1)
      cyc(300);
      `CHK(breakerTimeoutEvt, 1'b0)
      cyc(330);
      `CHK(breakerTimeoutEvt, r[0])
      @(posedge core_clk) breakerOffCmd <= 1'b0;
      machCircuitOpen <= 1'b0;
      cyc(5);
      `CHK(breakerOpenCmd, 1'b0)
    end
    wb(1'b1, `EFS_OFS_STATUS, 32'h0000_0020);
    cyc(3);
    `CHK(breakerTimeoutEvt, 1'b0)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0000);
    $display("breaker done");
  endtask : t_brk

  task automatic t_ramp;
    wb(1'b1, `EFS_OFS_RAMP_RATE, 32'h0000_0032);
    @(posedge core_clk) ctrlSigIn <= 16'h01F4;
    cyc(3);
    `CHK(ctrlSigOut, 16'h01F4)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0018);
    cyc(100);
    @(posedge core_clk) ctrlSigIn <= 16'h0000;
    cyc(700);
    `CHK(ctrlSigOut >= 16'h01FE && ctrlSigOut <= 16'h0212, 1'b1)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0028);
    cyc(800);
    `CHK(ctrlSigOut >= 16'h01EA && ctrlSigOut <= 16'h01FE, 1'b1)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0038);
    cyc(5);
    held = ctrlSigOut;
    cyc(400);
    `CHK(ctrlSigOut, held)
    wb(1'b1, `EFS_OFS_CTRL, 32'h0000_0000);
    cyc(3);
    `CHK(ctrlSigOut, 16'h0000)
    $display("ramp done");
  endtask : t_ramp

  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_ovc();
    t_of();
    t_temp();
    t_brk();
    t_ramp();
    conclude();
  end
endmodule : efs_supervisor_tb_top
